/* logic/mctd_pkg.sv */
// Package: constants and types for the memory controller test driver
package mctd_pkg;

  // ----------------------------------------------------------------
  // Data pattern generator
  // ----------------------------------------------------------------
  localparam int         LFSR_W      = 8;
  localparam logic [7:0] LFSR_TAPS   = 8'hB8;
  localparam logic [7:0] SEED_BASE   = 8'h5A;
  localparam logic [7:0] SEED_STEP   = 8'h1D;

  // ----------------------------------------------------------------
  // Default address geometry
  // ----------------------------------------------------------------
  localparam int         DEF_BYTES   = 4;
  localparam int         DEF_BANK_W  = 2;
  localparam int         DEF_ROW_W   = 13;
  localparam int         DEF_COL_W   = 9;
  localparam int         DEF_ROWS    = 2;
  localparam int         DEF_COLS    = 8;
  localparam int         DEF_BURST   = 1;
  localparam int         SIZE_W      = 2;

  // ----------------------------------------------------------------
  // Sequencer states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    MCTD_IDLE  = 5'h01,
    MCTD_WRITE = 5'h02,
    MCTD_WDONE = 5'h04,
    MCTD_READ  = 5'h08,
    MCTD_RWAIT = 5'h10
  } mctd_state_e;

endpackage : mctd_pkg

/* logic/mctd_driver.sv */
// Module: self-checking traffic generator for a DDR controller local port
// Contract
// - Issue read and write requests under control of a state machine.
// - Write patterns over configured columns and rows in every bank.
// - Read back every written location and compare with expected pattern.
// - Overall pass flag goes low on any read miscompare.
// - Per-byte pass vector reports comparison of each byte lane.
// - End-of-sequence output pulses one cycle after writes and after reads.
// - After the pulse that ends the reads, restart the test from the first address forever.
// - One 8-bit LFSR per lane, distinct seeds, regenerated for checking.
// - Compare only words qualified by read-data-valid, in request order.
module mctd_driver
  import mctd_pkg::*;
#(
  parameter int NBYTES = DEF_BYTES,
  parameter int BANK_W = DEF_BANK_W,
  parameter int ROW_W  = DEF_ROW_W,
  parameter int COL_W  = DEF_COL_W,
  parameter int NROWS  = DEF_ROWS,
  parameter int NCOLS  = DEF_COLS,
  parameter int BURST  = DEF_BURST
) (
  // Clock, reset, enable
  input  wire logic                    clk_in,
  input  wire logic                    sys_rst_in,
  input  wire logic                    clk_en_in,
  // Controller handshake
  input  wire logic                    local_init_done_in,
  input  wire logic                    local_ready_in,
  input  wire logic                    local_wdata_req_in,
  input  wire logic                    local_rdata_valid_in,
  input  wire logic [NBYTES*8-1:0]     local_rdata_in,
  // Request outputs
  output logic                         local_write_req_out,
  output logic                         local_read_req_out,
  output logic [SIZE_W-1:0]            local_size_out,
  output logic [BANK_W+ROW_W+COL_W-1:0] local_addr_out,
  output logic [NBYTES*8-1:0]          local_wdata_out,
  output logic [NBYTES-1:0]            local_be_out,
  // Status
  output logic                         pnf_out,
  output logic [NBYTES-1:0]            pnf_per_byte_out,
  output logic                         test_complete_out
);

  localparam int AW     = BANK_W + ROW_W + COL_W;
  localparam int DW     = NBYTES * 8;
  localparam int NBANKS = 1 << BANK_W;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [LFSR_W-1:0] lfsr_step(input logic [LFSR_W-1:0] v);
    lfsr_step = {v[LFSR_W-2:0], ^(v & LFSR_TAPS)};
  endfunction

  function automatic logic [DW-1:0] lfsr_seed();
    logic [DW-1:0] s;
    s = '0;
    for (int i = 0; i < NBYTES; i++) begin
      s[i*8 +: 8] = SEED_BASE + SEED_STEP * 8'(i);
    end
    lfsr_seed = s;
  endfunction

  // ----------------------------------------------------------------
  // State and counters
  // ----------------------------------------------------------------
  mctd_state_e          state_r;
  logic [COL_W-1:0]     col_r;
  logic [ROW_W-1:0]     row_r;
  logic [BANK_W-1:0]    bank_r;
  logic [31:0]          wbeat_r;
  logic [31:0]          rbeat_r;
  logic [31:0]          total_w;
  logic [DW-1:0]        wgen_r;
  logic [DW-1:0]        rgen_r;
  logic [DW-1:0]        wgen_nxt;
  logic [DW-1:0]        rgen_nxt;
  logic                 wdreq_d_r;

  wire logic req_on    = local_write_req_out | local_read_req_out;
  wire logic accept    = req_on & local_ready_in;
  wire logic last_col  = (32'(col_r) + 32'(BURST) >= 32'(NCOLS));
  wire logic last_row  = (32'(row_r) == 32'(NROWS - 1));
  wire logic last_bank = (32'(bank_r) == 32'(NBANKS - 1));
  wire logic last_addr = last_col & last_row & last_bank;
  wire logic [AW-1:0] addr_w = {bank_r, row_r, col_r};

  // Expected beats for one sweep: the write-data and read counters close on it
  assign total_w = 32'(NBANKS * NROWS * ((NCOLS + BURST - 1) / BURST) * BURST);

  generate
    for (genvar g = 0; g < NBYTES; g++) begin : g_lane
      assign wgen_nxt[g*8 +: 8] = lfsr_step(wgen_r[g*8 +: 8]);
      assign rgen_nxt[g*8 +: 8] = lfsr_step(rgen_r[g*8 +: 8]);
    end
  endgenerate

  // Per-lane compare of a qualified read word
  logic [NBYTES-1:0] lane_ok;
  generate
    for (genvar g = 0; g < NBYTES; g++) begin : g_cmp
      assign lane_ok[g] = (local_rdata_in[g*8 +: 8] == rgen_r[g*8 +: 8]);
    end
  endgenerate

  wire logic rd_hit  = (state_r inside {MCTD_READ, MCTD_RWAIT}) & local_rdata_valid_in;
  wire logic wr_last = wdreq_d_r & (wbeat_r == total_w - 32'd1);
  wire logic rd_last = rd_hit & (rbeat_r == total_w - 32'd1);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // The request is only moved on acceptance, so it stands while ready is low
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_r             <= MCTD_IDLE;
      col_r               <= '0;
      row_r               <= '0;
      bank_r              <= '0;
      local_write_req_out <= 1'b0;
      local_read_req_out  <= 1'b0;
      local_size_out      <= '0;
      local_addr_out      <= '0;
      test_complete_out   <= 1'b0;
    end else if (clk_en_in) begin
      test_complete_out <= 1'b0;
      case (state_r)
        MCTD_IDLE: begin
          if (local_init_done_in) begin
            state_r             <= MCTD_WRITE;
            local_write_req_out <= 1'b1;
            local_size_out      <= SIZE_W'(BURST);
            local_addr_out      <= addr_w;
          end
        end
        MCTD_WRITE, MCTD_READ: begin
          if (accept) begin
            if (last_addr) begin
              col_r               <= '0;
              row_r               <= '0;
              bank_r              <= '0;
              local_write_req_out <= 1'b0;
              local_read_req_out  <= 1'b0;
              state_r <= (state_r == MCTD_WRITE) ? MCTD_WDONE : MCTD_RWAIT;
            end else begin
              // Column fastest, then row, then bank: every bank covered
              if (last_col) begin
                col_r <= '0;
                if (last_row) begin
                  row_r  <= '0;
                  bank_r <= bank_r + 1'b1;
                end else begin
                  row_r <= row_r + 1'b1;
                end
              end else begin
                col_r <= col_r + COL_W'(BURST);
              end
            end
          end
          if (accept & ~last_addr) begin
            local_addr_out <= last_col ?
              (last_row ? {bank_r + 1'b1, {ROW_W{1'b0}}, {COL_W{1'b0}}}
                        : {bank_r, row_r + 1'b1, {COL_W{1'b0}}})
              : {bank_r, row_r, col_r + COL_W'(BURST)};
          end
        end
        MCTD_WDONE: begin
          // Wait for the last write beat before reading back
          if (wr_last) begin
            test_complete_out  <= 1'b1;
            state_r            <= MCTD_READ;
            local_read_req_out <= 1'b1;
            local_addr_out     <= '0;
          end
        end
        MCTD_RWAIT: begin
          if (rd_last) begin
            test_complete_out <= 1'b1;
            state_r           <= MCTD_IDLE;
          end
        end
        default: state_r <= MCTD_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Write data path
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      wdreq_d_r       <= 1'b0;
      wbeat_r         <= '0;
      wgen_r          <= lfsr_seed();
      local_wdata_out <= '0;
      local_be_out    <= '0;
    end else if (clk_en_in) begin
      wdreq_d_r <= local_wdata_req_in;
      if (local_wdata_req_in) begin
        local_wdata_out <= wgen_r;
        local_be_out    <= '1;
        wgen_r          <= wgen_nxt;
      end
      if (wdreq_d_r) begin
        wbeat_r <= wr_last ? 32'd0 : wbeat_r + 32'd1;
      end
      if (state_r == MCTD_IDLE) begin
        wgen_r  <= lfsr_seed();
        wbeat_r <= '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read check path
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rbeat_r          <= '0;
      rgen_r           <= lfsr_seed();
      pnf_out          <= 1'b1;
      pnf_per_byte_out <= '1;
    end else if (clk_en_in) begin
      if (rd_hit) begin
        rgen_r           <= rgen_nxt;
        rbeat_r          <= rd_last ? 32'd0 : rbeat_r + 32'd1;
        pnf_per_byte_out <= lane_ok;
        if (~&lane_ok) begin
          pnf_out <= 1'b0;
        end
      end else if (state_r == MCTD_IDLE) begin
        rgen_r  <= lfsr_seed();
        rbeat_r <= '0;
      end
    end
  end

endmodule // mctd_driver

/* dv/mctd_driver_assertions.sv */
// Checker for the test driver ports
module mctd_driver_assertions
  import mctd_pkg::*;
#(
  parameter int NBYTES = DEF_BYTES,
  parameter int AW     = 24
) (
  input wire logic              clk_in,
  input wire logic              sys_rst_in,
  input wire logic              clk_en_in,
  input wire logic              local_ready_in,
  input wire logic              local_wdata_req_in,
  input wire logic              local_rdata_valid_in,
  input wire logic              local_write_req_out,
  input wire logic              local_read_req_out,
  input wire logic [SIZE_W-1:0] local_size_out,
  input wire logic [AW-1:0]     local_addr_out,
  input wire logic [NBYTES-1:0] local_be_out,
  input wire logic              pnf_out,
  input wire logic [NBYTES-1:0] pnf_per_byte_out,
  input wire logic              test_complete_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  a_req_hold: assert property ((local_write_req_out || local_read_req_out) && !local_ready_in
    && clk_en_in |=> $stable(local_addr_out) && $stable({local_write_req_out, local_read_req_out}))
    else $error("request dropped before acceptance");
  a_one_kind: assert property (!(local_write_req_out && local_read_req_out))
    else $error("read and write requested together");
  a_size_one: assert property (local_write_req_out |-> local_size_out == 2'h1)
    else $error("burst size wrong");
  a_pnf_sticky: assert property (!pnf_out |=> !pnf_out)
    else $error("pass flag recovered");
  a_pnf_reset: assert property (disable iff (1'b0) sys_rst_in && clk_en_in |=> pnf_out)
    else $error("pass flag low after reset");
  a_pnf_cause: assert property ($fell(pnf_out) |-> $past(local_rdata_valid_in))
    else $error("pass flag fell without read data");
  a_byte_cause: assert property ($fell(pnf_per_byte_out[1]) |-> $past(local_rdata_valid_in))
    else $error("byte flag fell without read data");
  a_done_pulse: assert property (test_complete_out && clk_en_in |=> !test_complete_out)
    else $error("end pulse longer than one cycle");
  a_be_ones: assert property (local_wdata_req_in && clk_en_in |=> &local_be_out)
    else $error("byte enables not all set");
  c_stall: cover property (local_write_req_out && !local_ready_in);
  c_done: cover property (test_complete_out);
  c_fail: cover property ($fell(pnf_out));
endmodule // mctd_driver_assertions

/* dv/mctd_ctrl_model.sv */
// Behavioural controller local port with stall and fault options
module mctd_ctrl_model #(
  parameter int AW = 5
) (
  input  wire logic          clk_in,
  input  wire logic          rst_in,
  input  wire logic          slow_in,
  input  wire logic          flip_in,
  input  wire logic          wr_in,
  input  wire logic          rd_in,
  input  wire logic [AW-1:0] addr_in,
  input  wire logic [15:0]   wdata_in,
  output logic               ready_out,
  output logic               wreq_out,
  output logic               rvalid_out,
  output logic [15:0]        rdata_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0]   mem [0:2**AW-1];
  logic [AW-1:0] wa1, wa2;
  logic          cap;
  logic [1:0]    cnt;
  // Slow mode accepts one cycle in four
  assign ready_out = !slow_in || cnt == 2'h3;
  always_ff @(posedge clk_in) begin
    cnt <= rst_in ? 2'h0 : cnt + 2'h1;
    wreq_out <= wr_in && ready_out && !rst_in;
    wa1 <= addr_in;
    wa2 <= wa1;
    cap <= wreq_out;
    if (cap) mem[wa2] <= wdata_in;
    rvalid_out <= rd_in && ready_out && !rst_in;
    // Idle bus toggles so stale data is never mistaken for a word
    rdata_out <= (rd_in && ready_out) ? mem[addr_in] ^ {7'h00, flip_in, 8'h00} : ~rdata_out;
  end
endmodule // mctd_ctrl_model

/* dv/testbench.sv */
// Testbench: test driver against the controller model
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import mctd_pkg::*;
  localparam int AW = 5;
  localparam int NW = 8; // 2 banks, 2 rows, 2 columns
  logic          clk_in, sys_rst_in, clk_en_in, init_done, ready, wreq, rvalid, wr, rd;
  logic          done, pnf, slow, flip;
  logic [1:0]    size, be, pnf_b;
  logic [AW-1:0] addr;
  logic [15:0]   wdata, rdata;
  int            n_fail, tests_run, cyc, n_wr, n_rd;
  mctd_driver #(.NBYTES(2), .BANK_W(1), .ROW_W(2), .COL_W(2), .NROWS(2), .NCOLS(2), .BURST(1))
  mctd_driver_i (.clk_in, .sys_rst_in, .clk_en_in, .local_init_done_in(init_done),
    .local_ready_in(ready), .local_wdata_req_in(wreq), .local_rdata_valid_in(rvalid),
    .local_rdata_in(rdata), .local_write_req_out(wr), .local_read_req_out(rd),
    .local_size_out(size), .local_addr_out(addr), .local_wdata_out(wdata), .local_be_out(be),
    .pnf_out(pnf), .pnf_per_byte_out(pnf_b), .test_complete_out(done));
  mctd_ctrl_model #(.AW(AW)) mctd_ctrl_model_i (.clk_in, .rst_in(sys_rst_in), .slow_in(slow),
    .flip_in(flip), .wr_in(wr), .rd_in(rd), .addr_in(addr), .wdata_in(wdata),
    .ready_out(ready), .wreq_out(wreq), .rvalid_out(rvalid), .rdata_out(rdata));
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  // Request counts clear in reset, not on restart, so the first run after reset is judged from its own start
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (sys_rst_in) begin
      n_wr <= 0;
      n_rd <= 0;
    end else begin
      if (wr && ready) n_wr <= n_wr + 1;
      if (rd && ready) n_rd <= n_rd + 1;
    end
    if (cyc == 5000) begin
      n_fail++;
      close_out();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_done();
    @(negedge clk_in);
    while (done !== 1'b1) @(negedge clk_in);
  endtask
  task automatic do_reset();
    sys_rst_in = 1'b1;
    repeat (12) @(negedge clk_in);
    sys_rst_in = 1'b0;
  endtask
  // Start gate: no request before init done, nothing moves while disabled
  task automatic t_hold();
    repeat (4) @(negedge clk_in);
    chk(wr, 0);
    clk_en_in = 1'b0;
    init_done = 1'b1;
    repeat (4) @(negedge clk_in);
    chk(wr, 0);
    clk_en_in = 1'b1;
    @(negedge clk_in);
    chk({wr, rd, addr}, 7'h40);
  endtask
  // Stalling controller: full pass, counts, readback and restart
  task automatic t_clean();
    slow = 1'b1;
    wait_done();
    chk(n_wr, NW);
    chk(n_rd, 0);
    chk(mctd_ctrl_model_i.mem[0], {SEED_BASE + SEED_STEP, SEED_BASE});
    wait_done();
    chk(n_rd, NW);
    chk({pnf, pnf_b}, 3'h7);
    // Restart request shows one edge after the end pulse, before any acceptance
    @(negedge clk_in);
    chk({wr, addr}, 6'h20);
  endtask
  // Corrupted lane 1 on every read, then clean pass: flag stays low
  task automatic t_fault();
    slow = 1'b0;
    flip = 1'b1;
    wait_done();
    wait_done();
    repeat (2) @(negedge clk_in);
    chk({pnf, pnf_b}, 3'h1);
    flip = 1'b0;
    wait_done();
    wait_done();
    repeat (2) @(negedge clk_in);
    chk({pnf, pnf_b}, 3'h3);
    do_reset();
    chk(pnf, 1);
  endtask
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    {sys_rst_in, clk_en_in, init_done, slow, flip} = 5'h18;
    {n_fail, tests_run, cyc} = 0;
    do_reset();
    t_hold();
    t_clean();
    t_fault();
    close_out();
  end
endmodule // testbench
bind mctd_driver mctd_driver_assertions #(.NBYTES(NBYTES), .AW(BANK_W + ROW_W + COL_W))
  mctd_driver_assertions_i (.clk_in, .sys_rst_in, .clk_en_in, .local_ready_in,
  .local_wdata_req_in, .local_rdata_valid_in, .local_write_req_out, .local_read_req_out,
  .local_size_out, .local_addr_out, .local_be_out, .pnf_out, .pnf_per_byte_out,
  .test_complete_out);
